// >>> rtl/lcb_port.sv
`timescale 1ns/1ps

// Summary of operation
// - Five address pins directly reach each of the first 32 registers.
// - Pointer at 0x00, window at 0x01; window accesses use the pointer's target.
// - The pointer also reaches registers above 1Fh.
// - Addressing method chosen per transaction, no mode setting.
// - Latch strobe falling edge captures low five data lines as address.
// - Drive read data while select and read strobe asserted, release otherwise.
// - Write commits when select or write strobe is negated.
// - 8-bit mode moves one byte per access for registers and buffer.
// - 16-bit mode: registers bytewise, buffer one word per access.
// - In 16-bit mode a swap bit exchanges bytes written into the buffer.
module lcb_port (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       ce,
  input  wire logic                       cs_n,
  input  wire logic                       read_strobe_n,
  input  wire logic                       write_strobe_n,
  input  wire logic                       ale,
  input  wire logic [lcb_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [lcb_pkg::DATA_W-1:0] data_in,
  output logic      [lcb_pkg::DATA_W-1:0] data_out,
  output logic                            data_oe_n
);

  // ********************************************************
  // Pin synchronisation
  // ********************************************************
  lcb_pkg::lcb_pins_t    pins_raw;
  lcb_pkg::lcb_pins_t    pins_s;
  lcb_pkg::lcb_state_s_t s_q;
  lcb_pkg::lcb_state_s_t s_d;

  logic                       rd_go;
  logic                       wr_go;
  logic [lcb_pkg::ADDR_W-1:0] a5;
  logic [7:0]                 tgt;
  logic                       wide;
  logic                       swap;
  logic                       fifo_empty;
  logic                       fifo_full;
  logic [lcb_pkg::FIFO_IW:0]  fifo_cnt;
  logic [lcb_pkg::DATA_W-1:0] rd_val;
  logic [lcb_pkg::DATA_W-1:0] head;
  logic [lcb_pkg::DATA_W-1:0] wdat;
  logic [lcb_pkg::CFG_IW-1:0] tgt_lo;
  logic [lcb_pkg::CFG_IW-1:0] ptr_lo;
  logic [7:0]                 cfg_at_ptr;

  assign pins_raw = '{cs_n: cs_n, rd_n: read_strobe_n, wr_n: write_strobe_n,
                      ale: ale, addr: addr_in, data: data_in};

  lcb_sync #(
    .W   ($bits(lcb_pkg::lcb_pins_t)),
    .RST (lcb_pkg::PINS_RST)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .d    (pins_raw),
    .q    (pins_s)
  );

  // ********************************************************
  // Address resolution and read mux
  // ********************************************************
  assign rd_go      = !pins_s.cs_n && !pins_s.rd_n;
  assign wr_go      = !pins_s.cs_n && !pins_s.wr_n;
  assign a5         = s_q.aval ? s_q.alat : pins_s.addr;
  assign tgt        = (a5 == lcb_pkg::REG_WIN[4:0]) ? s_q.ptr : {3'h0, a5};
  assign tgt_lo     = tgt[lcb_pkg::CFG_IW-1:0];
  assign ptr_lo     = s_q.ptr[lcb_pkg::CFG_IW-1:0];
  assign cfg_at_ptr = s_q.cfg[ptr_lo];
  assign wide       = s_q.lbc[lcb_pkg::LBC_WIDE_BIT];
  assign swap       = s_q.lbc[lcb_pkg::LBC_SWAP_BIT];
  assign fifo_cnt   = s_q.wp - s_q.rp;
  assign fifo_empty = (s_q.wp == s_q.rp);
  assign fifo_full  = (s_q.wp[lcb_pkg::FIFO_IW] != s_q.rp[lcb_pkg::FIFO_IW]) &&
                      (s_q.wp[lcb_pkg::FIFO_IW-1:0] == s_q.rp[lcb_pkg::FIFO_IW-1:0]);
  assign head       = s_q.fifo[s_q.rp[lcb_pkg::FIFO_IW-1:0]];
  assign wdat       = pins_s.data;

  always_comb
  begin
    rd_val = '0;
    unique case (tgt)
      lcb_pkg::REG_PTR:
        rd_val[7:0] = s_q.ptr;
      lcb_pkg::REG_LBC:
        rd_val[7:0] = s_q.lbc;
      lcb_pkg::REG_BUF:
      begin
        if (wide)
          rd_val = head;
        else
          rd_val[7:0] = s_q.rd_half ? head[15:8] : head[7:0];
      end
      lcb_pkg::REG_BSTAT:
      begin
        rd_val[lcb_pkg::BST_CNT_LSB +: lcb_pkg::FIFO_IW+1] = fifo_cnt;
        rd_val[lcb_pkg::BST_FULL_BIT] = fifo_full;
        rd_val[lcb_pkg::BST_EMPT_BIT] = fifo_empty;
      end
      default:
      begin
        if (tgt <= lcb_pkg::CFG_TOP)
          rd_val[7:0] = s_q.cfg[tgt_lo];
      end
    endcase
  end

  // ********************************************************
  // Transaction sequencing
  // ********************************************************
  always_comb
  begin
    s_d = s_q;
    if (ce)
    begin
      s_d.ale_q = pins_s.ale;
      unique case (s_q.st)
        lcb_pkg::ST_IDLE:
        begin
          if (s_q.ale_q && !pins_s.ale)
          begin
            s_d.alat = pins_s.data[lcb_pkg::ADDR_W-1:0];
            s_d.aval = 1'b1;
          end
          if (rd_go)
          begin
            s_d.st   = lcb_pkg::ST_READ;
            s_d.dout = rd_val;
            s_d.oe_n = 1'b0;
            if (tgt == lcb_pkg::REG_BUF && !fifo_empty)
            begin
              if (wide || s_q.rd_half)
              begin
                s_d.rp      = s_q.rp + 1'b1;
                s_d.rd_half = 1'b0;
              end
              else
                s_d.rd_half = 1'b1;
            end
          end
          else if (wr_go)
            s_d.st = lcb_pkg::ST_WRITE;
        end
        lcb_pkg::ST_READ:
        begin
          if (!rd_go)
          begin
            s_d.st   = lcb_pkg::ST_IDLE;
            s_d.oe_n = 1'b1;
            s_d.aval = 1'b0;
          end
        end
        lcb_pkg::ST_WRITE:
        begin
          if (!wr_go)
          begin
            s_d.st   = lcb_pkg::ST_IDLE;
            s_d.aval = 1'b0;
            unique case (tgt)
              lcb_pkg::REG_PTR:
                s_d.ptr = wdat[7:0];
              lcb_pkg::REG_LBC:
                s_d.lbc = wdat[7:0];
              lcb_pkg::REG_BSTAT:
                s_d.st = lcb_pkg::ST_IDLE;
              lcb_pkg::REG_BUF:
              begin
                if (!fifo_full)
                begin
                  if (wide)
                  begin
                    s_d.fifo[s_q.wp[lcb_pkg::FIFO_IW-1:0]] =
                      swap ? {wdat[7:0], wdat[15:8]} : wdat;
                    s_d.wp = s_q.wp + 1'b1;
                  end
                  else if (!s_q.wr_half)
                  begin
                    s_d.fifo[s_q.wp[lcb_pkg::FIFO_IW-1:0]][7:0] = wdat[7:0];
                    s_d.wr_half = 1'b1;
                  end
                  else
                  begin
                    s_d.fifo[s_q.wp[lcb_pkg::FIFO_IW-1:0]][15:8] = wdat[7:0];
                    s_d.wr_half = 1'b0;
                    s_d.wp      = s_q.wp + 1'b1;
                  end
                end
              end
              default:
              begin
                if (tgt <= lcb_pkg::CFG_TOP)
                  s_d.cfg[tgt_lo] = wdat[7:0];
              end
            endcase
          end
        end
        default:
          s_d.st = lcb_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q         <= '0;
      s_q.st      <= lcb_pkg::ST_IDLE;
      s_q.ptr     <= lcb_pkg::PTR_RST;
      s_q.lbc     <= lcb_pkg::LBC_RST;
      s_q.cfg     <= {lcb_pkg::CFG_N{lcb_pkg::CFG_RST}};
      s_q.oe_n    <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign data_out  = s_q.dout;
  assign data_oe_n = s_q.oe_n;

  // ********************************************************
  // Assertions
  // ********************************************************
  localparam int ACC_MAX = lcb_pkg::RD_ACC_CYC;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence rd_begin_s;
    ce && s_q.st == lcb_pkg::ST_IDLE && rd_go;
  endsequence

  sequence wr_end_s;
    ce && s_q.st == lcb_pkg::ST_WRITE && !wr_go;
  endsequence

  read_drive_time_a: assert property (
    rd_begin_s |-> ##[1:ACC_MAX] !data_oe_n)
    else $error("read data not driven in time");

  read_release_a: assert property (
    ce && s_q.st == lcb_pkg::ST_READ && !rd_go |=> data_oe_n)
    else $error("data bus not released after read");

  write_pointer_a: assert property (
    wr_end_s and (a5 == lcb_pkg::REG_PTR[4:0]) |=> s_q.ptr == $past(wdat[7:0]))
    else $error("pointer write not committed at strobe end");

  window_read_a: assert property (
    rd_begin_s and (a5 == lcb_pkg::REG_WIN[4:0]) and
    (s_q.ptr > 8'h1f) and (s_q.ptr <= lcb_pkg::CFG_TOP)
    |=> data_out[7:0] == $past(cfg_at_ptr))
    else $error("window read did not follow pointer");

  ale_latch_a: assert property (
    ce && s_q.st == lcb_pkg::ST_IDLE && s_q.ale_q && !pins_s.ale
    |=> s_q.aval && s_q.alat == $past(pins_s.data[4:0]))
    else $error("latched address wrong");

  latch_hold_a: assert property (
    s_q.aval && s_q.st != lcb_pkg::ST_IDLE && $stable(s_q.st)
    |-> $stable(s_q.alat))
    else $error("latched address changed during transaction");

  direct_read_a: assert property (
    rd_begin_s and !s_q.aval and (pins_s.addr == lcb_pkg::REG_LBC[4:0])
    |=> data_out[7:0] == $past(s_q.lbc) && !data_oe_n)
    else $error("direct register read wrong");

  word_write_a: assert property (
    wr_end_s and (tgt == lcb_pkg::REG_BUF) and wide and !fifo_full
    |=> s_q.wp == $past(s_q.wp) + 5'h01)
    else $error("word write did not advance buffer");

  byte_pair_a: assert property (
    wr_end_s and (tgt == lcb_pkg::REG_BUF) and !wide and !fifo_full and !s_q.wr_half
    |=> $stable(s_q.wp) && s_q.wr_half)
    else $error("byte write advanced buffer early");

  swap_write_a: assert property (
    wr_end_s and (tgt == lcb_pkg::REG_BUF) and wide and swap and !fifo_full
    |=> s_q.fifo[$past(s_q.wp[3:0])] == {$past(wdat[7:0]), $past(wdat[15:8])})
    else $error("byte swap not applied");

endmodule

// >>> rtl/lcb_pkg.sv
package lcb_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int ADDR_W  = 5;
  localparam int DATA_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int CFG_N   = 64;
  localparam int CFG_IW  = 6;
  localparam int FIFO_N  = 16;
  localparam int FIFO_IW = 4;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [7:0] REG_PTR   = 8'h00;
  localparam logic [7:0] REG_WIN   = 8'h01;
  localparam logic [7:0] REG_LBC   = 8'h02;
  localparam logic [7:0] REG_BUF   = 8'h03;
  localparam logic [7:0] REG_BSTAT = 8'h04;
  localparam logic [7:0] CFG_TOP   = 8'h3f;

  // Local bus control fields
  localparam int LBC_WIDE_BIT = 0;
  localparam int LBC_SWAP_BIT = 1;

  // Buffer status fields
  localparam int BST_CNT_LSB  = 0;
  localparam int BST_FULL_BIT = 5;
  localparam int BST_EMPT_BIT = 6;

  // Reset values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] LBC_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_MHZ          = 125;
  localparam int RD_RD_REC_NS     = 33;
  localparam int WR_WR_REC_NS     = 55;
  localparam int RD_ACC_NS        = 35;
  localparam int RD_RD_REC_CYC    = (RD_RD_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_WR_REC_CYC    = (WR_WR_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_ACC_CYC       = (RD_ACC_NS * CLK_MHZ) / 1000;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} lcb_state_t;

  typedef struct packed {
    logic                  cs_n;
    logic                  rd_n;
    logic                  wr_n;
    logic                  ale;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     data;
  } lcb_pins_t;

  // Pin levels of an idle bus, so no false strobe follows reset
  localparam lcb_pins_t PINS_RST = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0,
                                     addr: '0, data: '0};

  typedef struct packed {
    lcb_state_t                        st;
    logic [7:0]                        ptr;
    logic [7:0]                        lbc;
    logic [CFG_N-1:0][BYTE_W-1:0]      cfg;
    logic [FIFO_N-1:0][DATA_W-1:0]     fifo;
    logic [FIFO_IW:0]                  wp;
    logic [FIFO_IW:0]                  rp;
    logic                              wr_half;
    logic                              rd_half;
    logic                              ale_q;
    logic [ADDR_W-1:0]                 alat;
    logic                              aval;
    logic [DATA_W-1:0]                 dout;
    logic                              oe_n;
  } lcb_state_s_t;

endpackage

// >>> rtl/lcb_sync.sv
`timescale 1ns/1ps

module lcb_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ********************************************************
  // Two-stage synchroniser
  // ********************************************************
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= RST;
      q      <= RST;
    end
    else if (ce)
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// >>> test/lcb_host.sv
`timescale 1ns/1ps

// ********************************************************
// Local bus master model
// ********************************************************
module lcb_host (
  input  wire logic                       clk,
  output logic                            cs_n,
  output logic                            read_strobe_n,
  output logic                            write_strobe_n,
  output logic                            ale,
  output logic [lcb_pkg::ADDR_W-1:0]      addr_in,
  output logic [lcb_pkg::DATA_W-1:0]      data_in,
  input  wire logic [lcb_pkg::DATA_W-1:0] data_out,
  input  wire logic                       data_oe_n
);
  logic [lcb_pkg::DATA_W-1:0] hd;
  logic                       hoe;
  logic [lcb_pkg::DATA_W-1:0] flt;

  // Wire level: clash shows as unknown, a floating bus keeps changing
  assign data_in = (!data_oe_n && hoe) ? 'x : (!data_oe_n ? data_out : (hoe ? hd : flt));

  initial
  begin
    cs_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    ale = 1'b0;
    addr_in = 5'h00;
    hd = 16'h0000;
    hoe = 1'b0;
    flt = 16'h0f0f;
  end

  always @(posedge clk)
    flt <= {flt[14:0], ~flt[15]};

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One transfer; oe gives the enable mid-access and after release
  task automatic xfer(input logic wr, input logic mux, input logic [4:0] a,
                      input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] oe);
    if (mux)
    begin
      hd = {11'h000, a};
      hoe = 1'b1;
      ale = 1'b1;
      cyc(3);
      ale = 1'b0;
      cyc(3);
      hoe = 1'b0;
      addr_in = ~a;
      cyc(1);
    end
    else
      addr_in = a;
    hd = wd;
    hoe = wr;
    cs_n = 1'b0;
    if (wr)
      write_strobe_n = 1'b0;
    else
      read_strobe_n = 1'b0;
    cyc(6);
    rd = data_in;
    oe[1] = data_oe_n;
    cs_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    cyc(4);
    oe[0] = data_oe_n;
    hoe = 1'b0;
    cyc(6);
  endtask
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps

module testbench;
  logic                       clk;
  logic                       nrst;
  logic                       ce;
  logic                       cs_n;
  logic                       rd_n;
  logic                       wr_n;
  logic                       ale;
  logic [lcb_pkg::ADDR_W-1:0] addr;
  logic [lcb_pkg::DATA_W-1:0] din;
  logic [lcb_pkg::DATA_W-1:0] dout;
  logic                       oe_n;
  int                         n_fail;
  int                         checks_done;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  lcb_port i_dut (.clk(clk), .nrst(nrst), .ce(ce), .cs_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .ale(ale), .addr_in(addr), .data_in(din), .data_out(dout),
    .data_oe_n(oe_n));

  lcb_host i_host (.clk(clk), .cs_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .ale(ale), .addr_in(addr), .data_in(din), .data_out(dout), .data_oe_n(oe_n));

  // ********************************************************
  // Checking and reporting
  // ********************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
      n_fail++;
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic done_t(input string s);
    $display("test %s finished", s);
  endtask

  task automatic reset_dut(input int n);
    nrst = 1'b0;
    repeat (n) @(negedge clk);
    check("enable in reset", {15'h0000, oe_n}, 16'h0001);
    check("data in reset", dout, 16'h0000);
    nrst = 1'b1;
    repeat (2)
    begin
      @(negedge clk);
      check("enable after reset", {15'h0000, oe_n}, 16'h0001);
    end
    @(negedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic mux = 1'b0);
    logic [15:0] r;
    logic [1:0]  oe;
    i_host.xfer(1'b1, mux, a, d, r, oe);
    check("write enable", {14'h0000, oe}, 16'h0003);
  endtask

  task automatic rdc(input string what, input logic [4:0] a, input logic [15:0] exp,
                     input logic mux = 1'b0);
    logic [15:0] r;
    logic [1:0]  oe;
    i_host.xfer(1'b0, mux, a, 16'h0000, r, oe);
    check(what, r, exp);
    check("read enable", {14'h0000, oe}, 16'h0001);
  endtask

  // ********************************************************
  // Tests
  // ********************************************************
  initial
  begin
    ce = 1'b1;
    n_fail = 0;
    checks_done = 0;
    reset_dut(20);
    rdc("pointer reset", 5'h00, 16'h0000);
    rdc("control reset", 5'h02, 16'h0000);
    rdc("status reset", 5'h04, 16'h0040);
    done_t("reset");
    for (int a = 5; a < 32; a++)
      wr(a[4:0], {8'hff, a[7:0] ^ 8'ha5});
    for (int a = 5; a < 32; a++)
      rdc("direct", a[4:0], {8'h00, a[7:0] ^ 8'ha5});
    ce = 1'b0;
    wr(5'h05, 16'h0077);
    ce = 1'b1;
    rdc("frozen write", 5'h05, 16'h00a0);
    wr(5'h04, 16'h00ff);
    rdc("status read only", 5'h04, 16'h0040);
    done_t("direct");
    wr(5'h00, 16'h0025);
    wr(5'h01, 16'h00c3);
    rdc("pointer", 5'h00, 16'h0025);
    rdc("window high", 5'h01, 16'h00c3);
    wr(5'h00, 16'h0010);
    rdc("window low", 5'h01, 16'h00b5);
    wr(5'h00, 16'h0050);
    rdc("window beyond", 5'h01, 16'h0000);
    done_t("indirect");
    wr(5'h07, 16'h003c, 1'b1);
    rdc("mux write", 5'h07, 16'h003c);
    rdc("pins ignored", 5'h18, 16'h00bd);
    rdc("mux read", 5'h07, 16'h003c, 1'b1);
    rdc("latch cleared", 5'h09, 16'h00ac);
    done_t("multiplexed");
    for (int i = 1; i < 5; i++)
      wr(5'h03, {8'hee, 8'(i * 17)});
    rdc("buffer count", 5'h04, 16'h0002);
    for (int i = 1; i < 5; i++)
      rdc("buffer byte", 5'h03, {8'h00, 8'(i * 17)});
    rdc("buffer drained", 5'h04, 16'h0040);
    done_t("byte mode");
    wr(5'h02, 16'h0001);
    rdc("control wide", 5'h02, 16'h0001);
    wr(5'h03, 16'ha1b2);
    rdc("buffer word", 5'h03, 16'ha1b2);
    wr(5'h02, 16'h0003);
    wr(5'h03, 16'ha1b2);
    rdc("buffer swapped", 5'h03, 16'hb2a1);
    done_t("word mode");
    reset_dut(2);
    rdc("pointer after reset", 5'h00, 16'h0000);
    rdc("control after reset", 5'h02, 16'h0000);
    done_t("reset again");
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("[ERR] watchdog expected finish seen timeout");
    stop_test();
  end
endmodule
